// File: rtl/pdmc_device.sv
// device end: power-down control registers, module clock gates, sleep and standby sequencing
// Notes on behaviour
// - control register 2: 8 bits, RW, reset zero
// - software writes one into reserved bit 7
// - relatch mode pins on standby exit if enabled
// - bit 5 stops break controller clock
// - bit 4 stops dma controller clock
// - bit 3 stops digital-to-analog clock
// - bit 2 stops analog-to-digital clock, initializes it
// - bit 1 stops fifo serial clock
// - bit 0 stops infrared serial clock
// - sleep with select zero halts core, keeps state
// - sleep keeps peripherals and clock outputs running
// - sleep drives state pins high, low
// - interrupts or reset end sleep, ignore block
// - interrupt wakeup stores code in both registers
// - power-on or manual reset ends sleep
// - avoid dma in sleep unless clocks 1:1
// - sleep with select one enters standby
// - standby clears timer start, initializes adc
// - software stops and prepares watchdog first
// - set standby select before sleep instruction
// - standby drives state pins low, high
// - state pins: reset HH, sleep HL, standby LH, normal LL
// - standby select is bit 7, resets zero
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pdmc_device #(
  parameter int EVT_W = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  pdmc_if.device lnk,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ==========================================================
  // registers
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  pdmc_pkg::pdmc_mode_e mode_reg;
  pdmc_pkg::pdmc_mode_e mode_next;
  logic [5:0] mode_latched_reg;
  logic [EVT_W-1:0] evt_reg;
  logic int_take_reg;
  logic tstart_clr_reg;
  logic mreset_reg;
  logic [7:0] rdata_reg;
  logic [5:0] gate_en_lat;

  // ==========================================================
  // decode
  wire wr_ctrl1 = reg_wr && (reg_addr == pdmc_pkg::PDMC_OFF_CTRL1);
  wire wr_ctrl2 = reg_wr && (reg_addr == pdmc_pkg::PDMC_OFF_CTRL2);
  wire standby_select = ctrl1_reg[pdmc_pkg::PDMC_BIT_STANDBY_SELECT];
  wire mode_pin_relatch = ctrl2_reg[pdmc_pkg::PDMC_BIT_MODE_PIN_RELATCH];
  // interrupts wake both modes regardless of the core block bit
  wire wake_int = lnk.int_req;
  wire wake_any = wake_int || lnk.manual_reset;
  wire in_standby = (mode_reg == pdmc_pkg::PDMC_STANDBY);
  wire in_sleep = (mode_reg == pdmc_pkg::PDMC_SLEEP);
  // the core counts as halted in either low-power mode
  wire halted_now = (mode_reg != pdmc_pkg::PDMC_RUN);
  // an interrupt wake starts exception handling; a reset in the same cycle wins
  wire int_wake = halted_now && wake_int && !lnk.manual_reset;
  // timer start is cleared once, on the way into standby
  wire enter_standby = (mode_reg == pdmc_pkg::PDMC_RUN) &&
                       (mode_next == pdmc_pkg::PDMC_STANDBY);
  // straps are taken again only when standby ends with the enable bit set
  wire relatch_now = in_standby && wake_any && mode_pin_relatch;

  // control registers; power-on reset only, manual reset keeps them
  // bit 7 of register 2 is stored as written; software is expected to keep it at one
  // only the standby select of register 1 lives here, its other fields read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_reg <= pdmc_pkg::PDMC_CTRL1_RESET;
      ctrl2_reg <= pdmc_pkg::PDMC_CTRL2_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_reg <= reg_wdata & pdmc_pkg::PDMC_CTRL1_MASK;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= reg_wdata; // bit 7 stored as written
      end
    end
  end

  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pdmc_pkg::PDMC_RUN: begin
        if (lnk.sleep_exec) begin
          mode_next = standby_select ? pdmc_pkg::PDMC_STANDBY : pdmc_pkg::PDMC_SLEEP;
        end
      end
      pdmc_pkg::PDMC_SLEEP: begin
        if (wake_any) begin
          mode_next = pdmc_pkg::PDMC_RUN;
        end
      end
      pdmc_pkg::PDMC_STANDBY: begin
        // wakes at once: the oscillator settling wait is not modelled here
        if (wake_any) begin
          mode_next = pdmc_pkg::PDMC_RUN;
        end
      end
      default: mode_next = pdmc_pkg::PDMC_RUN;
    endcase
  end

  // mode and wake pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= pdmc_pkg::PDMC_RUN;
      int_take_reg <= 1'b0;
      tstart_clr_reg <= 1'b0;
      mreset_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      mreset_reg <= lnk.manual_reset;
      int_take_reg <= int_wake;
      tstart_clr_reg <= enter_standby;
    end
  end

  // event code: written only by an interrupt wake, kept across both low-power modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_reg <= '0;
    end else if (int_wake) begin
      evt_reg <= EVT_W'(lnk.int_code);
    end
  end

  // mode pins: caught after reset release, refreshed on standby exit when enabled
  logic straps_taken_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_latched_reg <= '0;
      straps_taken_reg <= 1'b0;
    end else begin
      straps_taken_reg <= 1'b1;
      if (!straps_taken_reg || relatch_now) begin
        mode_latched_reg <= lnk.mode_pins;
      end
    end
  end

  // ==========================================================
  // module clock gates: one per stop bit, standby stops all
  genvar g;
  generate
    for (g = 0; g < pdmc_pkg::PDMC_NUM_GATES; g++) begin : gen_gate
      // a stop bit or standby closes the gate; the module keeps its own state
      wire gate_want = !ctrl2_reg[g] && !in_standby;
      // enable settles on clk low so a bit change never chops a pulse
      always_latch begin
        if (!clk) begin
          gate_en_lat[g] = gate_want;
        end
      end
      assign lnk.gated_clk[g] = clk & gate_en_lat[g];
    end
  endgenerate

  // ==========================================================
  // link outputs
  assign lnk.gate_en = gate_en_lat;
  // core halts in either low-power mode; its registers are untouched
  assign lnk.core_halt = (mode_reg != pdmc_pkg::PDMC_RUN);
  assign lnk.int_take = int_take_reg;
  assign lnk.int_event_code = evt_reg;
  assign lnk.int_event_code_2 = evt_reg;
  assign lnk.mode_latched = mode_latched_reg;
  assign lnk.adc_init = ctrl2_reg[pdmc_pkg::PDMC_BIT_ADC_STOP] || in_standby;
  assign lnk.timer_start_clear = tstart_clr_reg;
  // clock outputs run in run and sleep, stop in standby
  wire clk_out_run = !in_standby;
  assign lnk.clock_out_a = clk & clk_out_run;
  assign lnk.clock_out_b = clk & clk_out_run;
  // state pins; a manual reset shows as the reset code
  wire [1:0] ps_code = mreset_reg ? pdmc_pkg::PDMC_PS_RESET :
                       in_sleep ? pdmc_pkg::PDMC_PS_SLEEP :
                       in_standby ? pdmc_pkg::PDMC_PS_STANDBY :
                       pdmc_pkg::PDMC_PS_NORMAL;
  assign lnk.proc_state_1 = rst_b ? ps_code[1] : 1'b1;
  assign lnk.proc_state_0 = rst_b ? ps_code[0] : 1'b1;

  // ==========================================================
  // read port, data one cycle after the strobe
  wire sel_ctrl1 = (reg_addr == pdmc_pkg::PDMC_OFF_CTRL1);
  wire sel_ctrl2 = (reg_addr == pdmc_pkg::PDMC_OFF_CTRL2);
  wire sel_state = (reg_addr == pdmc_pkg::PDMC_OFF_STATE);
  wire sel_event = (reg_addr == pdmc_pkg::PDMC_OFF_EVENT);
  wire [7:0] rd_mux = sel_ctrl1 ? ctrl1_reg :
                      sel_ctrl2 ? ctrl2_reg :
                      sel_state ? {mode_reg, mode_latched_reg} :
                      sel_event ? evt_reg[7:0] : 8'h00;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule : pdmc_device
`default_nettype wire

// File: rtl/pdmc_host.sv
// host end: processor-side stand-in issuing sleep, interrupts and resets to the controller
`timescale 1ns/1ps
`default_nettype none
module pdmc_host (
  input wire logic clk,
  input wire logic rst_b,
  pdmc_if.host lnk,
  input wire logic cmd_sleep,
  input wire logic cmd_int,
  input wire logic [11:0] cmd_int_code,
  input wire logic cmd_manual_reset,
  input wire logic [5:0] straps,
  output logic halted,
  output logic irq_taken,
  output logic [11:0] taken_code,
  output logic [1:0] proc_state
);
  logic sleep_reg;
  logic int_reg;
  logic [11:0] code_reg;
  logic mrst_reg;
  logic taken_reg;
  logic [11:0] tcode_reg;

  // ==========================================================
  // requests; a sleep is issued only while running, as a one-cycle pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_reg <= 1'b0;
      int_reg <= 1'b0;
      code_reg <= 12'h000;
      mrst_reg <= 1'b0;
      taken_reg <= 1'b0;
      tcode_reg <= 12'h000;
    end else begin
      // software sets standby select before this pulse
      sleep_reg <= cmd_sleep && !lnk.core_halt && !sleep_reg;
      // interrupt level held until the device starts handling
      // a new request in the cycle the old one is taken must not be lost
      if (cmd_int) begin
        int_reg <= 1'b1;
        code_reg <= cmd_int_code;
      end else if (lnk.int_take) begin
        int_reg <= 1'b0;
      end
      mrst_reg <= cmd_manual_reset;
      taken_reg <= lnk.int_take;
      if (lnk.int_take) begin
        tcode_reg <= lnk.int_event_code;
      end
    end
  end

  assign lnk.sleep_exec = sleep_reg;
  assign lnk.int_req = int_reg;
  assign lnk.int_code = code_reg;
  assign lnk.manual_reset = mrst_reg;
  assign lnk.mode_pins = straps;
  assign halted = lnk.core_halt;
  assign irq_taken = taken_reg;
  assign taken_code = tcode_reg;
  assign proc_state = {lnk.proc_state_1, lnk.proc_state_0};
endmodule : pdmc_host
`default_nettype wire

// File: rtl/pdmc_if.sv
// interface: link between the processor side and the power-down mode controller
`timescale 1ns/1ps
`default_nettype none
interface pdmc_if;
  logic sleep_exec; // one-cycle pulse: core executed sleep instruction
  logic int_req; // level: an enabled interrupt source is pending
  logic [11:0] int_code; // code of the pending source
  logic manual_reset; // level: manual reset request
  logic [5:0] mode_pins; // board mode straps
  logic core_halt; // level: core must stay halted
  logic int_take; // one-cycle pulse: start interrupt exception handling
  logic [11:0] int_event_code; // event code register
  logic [11:0] int_event_code_2; // second event code register
  logic [5:0] mode_latched; // mode pin values in use
  logic [5:0] gate_en; // per-module clock gate enable
  logic [5:0] gated_clk; // per-module gated clock
  logic adc_init; // level: hold analog-to-digital registers initialized
  logic timer_start_clear; // one-cycle pulse: clear timer_start_reg
  logic clock_out_a; // external clock output a
  logic clock_out_b; // external clock output b
  logic proc_state_1;
  logic proc_state_0;
  modport device (
    input sleep_exec, int_req, int_code, manual_reset, mode_pins,
    output core_halt, int_take, int_event_code, int_event_code_2, mode_latched,
    output gate_en, gated_clk, adc_init, timer_start_clear, clock_out_a, clock_out_b,
    output proc_state_1, proc_state_0
  );
  modport host (
    output sleep_exec, int_req, int_code, manual_reset, mode_pins,
    input core_halt, int_take, int_event_code, int_event_code_2, mode_latched,
    input gate_en, gated_clk, adc_init, timer_start_clear, clock_out_a, clock_out_b,
    input proc_state_1, proc_state_0
  );
endinterface : pdmc_if
`default_nettype wire

// File: rtl/pdmc_pkg.sv
// package: constants and types shared by both ends of the power-down mode control block
package pdmc_pkg;
  // ==========================================================
  // register offsets on the plain register port (byte addresses)
  localparam logic [3:0] PDMC_OFF_CTRL1 = 4'h0; // power_down_control_1
  localparam logic [3:0] PDMC_OFF_CTRL2 = 4'h4; // power_down_control_2
  localparam logic [3:0] PDMC_OFF_STATE = 4'h8; // state and latched mode pins
  localparam logic [3:0] PDMC_OFF_EVENT = 4'hC; // int_event_code
  // ==========================================================
  // field positions
  localparam int PDMC_BIT_STANDBY_SELECT = 7;
  localparam int PDMC_BIT_RESERVED7 = 7;
  localparam int PDMC_BIT_MODE_PIN_RELATCH = 6;
  localparam int PDMC_BIT_BREAK_STOP = 5;
  localparam int PDMC_BIT_DMA_STOP = 4;
  localparam int PDMC_BIT_DAC_STOP = 3;
  localparam int PDMC_BIT_ADC_STOP = 2;
  localparam int PDMC_BIT_FIFO_SER_STOP = 1;
  localparam int PDMC_BIT_IR_SER_STOP = 0;
  localparam int PDMC_NUM_GATES = 6;
  localparam int PDMC_MODE_PINS = 6;
  localparam int PDMC_EVT_W = 12;
  // ==========================================================
  // reset values
  localparam logic [7:0] PDMC_CTRL1_RESET = 8'h00;
  localparam logic [7:0] PDMC_CTRL2_RESET = 8'h00;
  // writable bits of power_down_control_1 held here (only the standby select)
  localparam logic [7:0] PDMC_CTRL1_MASK = 8'h80;
  // ==========================================================
  // processing-state pin codes {proc_state_1, proc_state_0}
  localparam logic [1:0] PDMC_PS_RESET = 2'h3;
  localparam logic [1:0] PDMC_PS_SLEEP = 2'h2;
  localparam logic [1:0] PDMC_PS_STANDBY = 2'h1;
  localparam logic [1:0] PDMC_PS_NORMAL = 2'h0;
  // power modes
  typedef enum logic [1:0] {PDMC_RUN, PDMC_SLEEP, PDMC_STANDBY} pdmc_mode_e;
endpackage : pdmc_pkg

// File: verif/pdmc_properties.sv
// checker: timing relations on the power-down link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module pdmc_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sleep_exec,
  input wire logic int_req,
  input wire logic [11:0] int_code,
  input wire logic manual_reset,
  input wire logic core_halt,
  input wire logic int_take,
  input wire logic [11:0] int_event_code,
  input wire logic [11:0] int_event_code_2,
  input wire logic [5:0] gate_en,
  input wire logic adc_init,
  input wire logic timer_start_clear,
  input wire logic proc_state_1,
  input wire logic proc_state_0
);
  // ==========================================================
  // state pin pair as one code
  wire logic [1:0] ps = {proc_state_1, proc_state_0};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // halt entry and state pins
  property p_sleep_halt;
    sleep_exec && !core_halt |=> core_halt;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("no halt after sleep");
  property p_sleep_pins;
    ps == 2'h2 |-> core_halt;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep code while running");
  // ==========================================================
  // standby side effects; gates follow one clock low later
  property p_standby_select_gates;
    $rose(ps == 2'h1) |=> gate_en == 6'h00;
  endproperty
  a_standby_select_gates: assert property (p_standby_select_gates) else $error("gates run in standby");
  property p_standby_select_timer;
    $rose(ps == 2'h1) |-> timer_start_clear ##1 !timer_start_clear;
  endproperty
  a_standby_select_timer: assert property (p_standby_select_timer) else $error("timer clear pulse");
  property p_standby_select_adc;
    ps == 2'h1 |-> adc_init;
  endproperty
  a_standby_select_adc: assert property (p_standby_select_adc) else $error("adc not held");
  // ==========================================================
  // wakeup by interrupt or reset
  property p_wake;
    core_halt && int_req && !manual_reset |=> !core_halt && int_take;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_event;
    int_take |-> int_event_code == $past(int_code) && int_event_code_2 == $past(int_code);
  endproperty
  a_event: assert property (p_event) else $error("event code wrong");
  property p_mreset;
    manual_reset |=> ps == 2'h3;
  endproperty
  a_mreset: assert property (p_mreset) else $error("reset code missing");
  c_sleep: cover property ($rose(ps == 2'h2));
  c_standby_select: cover property ($rose(ps == 2'h1));
  c_take: cover property (int_take);
endmodule // pdmc_properties
`default_nettype wire

// File: verif/testbench.sv
// testbench: drives both ends of the power-down link through registers and host commands
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmd_sleep = 1'b0;
  logic cmd_int = 1'b0;
  logic [11:0] cmd_int_code = 12'h000;
  logic cmd_manual_reset = 1'b0;
  logic [5:0] straps = 6'h15;
  logic halted;
  logic irq_taken;
  logic [11:0] taken_code;
  logic [1:0] proc_state;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ==========================================================
  // clock and the two ends facing each other
  always #5 clk = ~clk;
  pdmc_if lnk ();
  pdmc_device pdmc_device_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pdmc_host pdmc_host_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .cmd_sleep(cmd_sleep),
    .cmd_int(cmd_int), .cmd_int_code(cmd_int_code), .cmd_manual_reset(cmd_manual_reset),
    .straps(straps), .halted(halted), .irq_taken(irq_taken), .taken_code(taken_code),
    .proc_state(proc_state));
  pdmc_properties pdmc_properties_inst (.clk(clk), .rst_b(rst_b),
    .sleep_exec(lnk.sleep_exec), .int_req(lnk.int_req), .int_code(lnk.int_code),
    .manual_reset(lnk.manual_reset), .core_halt(lnk.core_halt), .int_take(lnk.int_take),
    .int_event_code(lnk.int_event_code), .int_event_code_2(lnk.int_event_code_2),
    .gate_en(lnk.gate_en), .adc_init(lnk.adc_init), .timer_start_clear(lnk.timer_start_clear),
    .proc_state_1(lnk.proc_state_1), .proc_state_0(lnk.proc_state_0));
  // ==========================================================
  // shared tasks: compare, register access, host commands
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(12'(reg_rdata), 12'(exp), what);
  endtask
  task automatic host(input logic s, input logic i, input logic [11:0] c);
    @(posedge clk);
    cmd_sleep <= s;
    cmd_int <= i;
    cmd_int_code <= c;
    @(posedge clk);
    cmd_sleep <= 1'b0;
    cmd_int <= 1'b0;
  endtask
  // bounded wait on the state pins, then compare
  task automatic wait_ps(input logic [1:0] v, input string what);
    int k;
    k = 0;
    while (proc_state !== v && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(12'(proc_state), 12'(v), what);
  endtask
  // clocks are looked at in the high phase, where a running gate shows one
  task automatic clocks_hi(input logic [7:0] exp, input string what);
    @(posedge clk);
    #2;
    chk(12'({lnk.clock_out_a, lnk.clock_out_b, lnk.gated_clk}), 12'(exp), what);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("BAD t=%0t timeout", $time);
      report_and_stop();
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(pdmc_pkg::PDMC_OFF_CTRL2, 8'h00, "ctrl2 reset");
    rd(pdmc_pkg::PDMC_OFF_CTRL1, 8'h00, "ctrl1 reset");
    wait_ps(2'h0, "normal");
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h00, "unmapped");
    $display("test reset done");
    // one stop bit at a time, reserved bit written as one
    for (int i = 0; i < 6; i++) begin
      wr(pdmc_pkg::PDMC_OFF_CTRL2, 8'h80 | (8'h01 << i));
      rd(pdmc_pkg::PDMC_OFF_CTRL2, 8'h80 | (8'h01 << i), "ctrl2 rw");
      clocks_hi(~(8'h01 << i), "stop bit");
      chk(12'(lnk.adc_init), 12'(i == 2), "adc init");
    end
    wr(pdmc_pkg::PDMC_OFF_CTRL2, 8'hC0);
    $display("test gates done");
    host(1'b1, 1'b0, 12'h000);
    wait_ps(2'h2, "sleep pins");
    chk(12'(halted), 12'h001, "halted");
    clocks_hi(8'hFF, "sleep clocks");
    host(1'b0, 1'b1, 12'h5A3);
    wait_ps(2'h0, "sleep wake");
    // the host registers the handling pulse and its code one edge after the wake
    @(posedge clk);
    #1;
    chk(12'(irq_taken), 12'h001, "irq taken");
    chk(taken_code, 12'h5A3, "taken code");
    chk(lnk.int_event_code_2, 12'h5A3, "event code 2");
    rd(pdmc_pkg::PDMC_OFF_EVENT, 8'hA3, "event reg");
    // standby with relatch on: new straps appear only at wake
    @(posedge clk);
    straps <= 6'h2A;
    wr(pdmc_pkg::PDMC_OFF_CTRL1, 8'h80);
    host(1'b1, 1'b0, 12'h000);
    wait_ps(2'h1, "standby pins");
    clocks_hi(8'h00, "standby clocks");
    chk(12'(lnk.mode_latched), 12'h015, "pins held");
    host(1'b0, 1'b1, 12'h3C7);
    wait_ps(2'h0, "standby wake");
    chk(12'(lnk.mode_latched), 12'h02A, "relatched");
    rd(pdmc_pkg::PDMC_OFF_CTRL2, 8'hC0, "ctrl2 kept");
    $display("test modes done");
    wr(pdmc_pkg::PDMC_OFF_CTRL1, 8'h00);
    host(1'b1, 1'b0, 12'h000);
    wait_ps(2'h2, "sleep again");
    @(posedge clk);
    cmd_manual_reset <= 1'b1;
    wait_ps(2'h3, "reset pins");
    @(posedge clk);
    cmd_manual_reset <= 1'b0;
    wait_ps(2'h0, "reset wake");
    chk(12'(halted), 12'h000, "running");
    $display("test manual reset done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
